// >>> rtl/ecl_defines.svh
`ifndef ECL_DEFINES_SVH
`define ECL_DEFINES_SVH
// =====================================================================
// characters
`define ECL_CH_SOM      8'h23
`define ECL_CH_CR       8'h0D
`define ECL_CH_LF       8'h0A
`define ECL_CH_ACK      8'h40
`define ECL_CH_NAK      8'h3F
// =====================================================================
// timing
`define ECL_CLK_HZ      40000000
`define ECL_MS_CYCLES   (`ECL_CLK_HZ / 1000)
`define ECL_MS_PER_S    1000
`define ECL_BITS_CHAR   10
`define ECL_ACK_CHARS   9
`define ECL_BAUD_MIN    1200
`define ECL_BAUD_MAX    38400
`define ECL_BAUD_RST    9600
// =====================================================================
// rf channel limits
`define ECL_CHAN_MAX    12'h118
`endif

// >>> rtl/ecl_pkg.sv
package ecl_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ecl_char_type;

  typedef struct packed {
    logic        valid;
    logic        is_ack;
    logic        crc_ok;
    logic [7:0]  seq;
    logic [7:0]  code;
  } ecl_frame_type;

  typedef enum logic [3:0] {
    ECL_TX_IDLE = 4'b0001,
    ECL_TX_WAIT = 4'b0010,
    ECL_TX_CMD  = 4'b0100,
    ECL_TX_RESP = 4'b1000
  } ecl_tx_state_type;
endpackage

// >>> rtl/ecl_link_engine.sv
`timescale 1ns/100ps
`include "ecl_defines.svh"
// Function
// [RULE_01] set-RF-channel accepted only with hex argument 000 to 118.
// [RULE_02] well-formed illegal command or illegal data gets error response; code sets cmd_error only for set-RF-channel with a bad argument.
// [RULE_03] one timeout setting serves ack wait and receive bound; code keeps separate rx_to_ms and tx_to_ms.
// [RULE_04] receive timeout covers message length times char plus idle time.
// [RULE_05] baud rate configurable 1200 to 38400, timeouts scale with it.
// [RULE_06] ack timeout is nine char times plus error-check allowance.
// [RULE_07] new serial parameters: send completion, then apply at once.
// [RULE_08] host switches its parameters right after that transaction.
// [RULE_09] sender times out, declares logical NAK, retransmits until acked.
// [RULE_10] receiver drops partial message if end not seen before timeout.
// [RULE_11] second start char aborts message and restarts acquisition.
// [RULE_12] RF reading disabled in command mode.
// [RULE_13] illegal sequence digit: command dropped, ack treated as NAK.
// [RULE_14] mismatched ack sequence digit treated as NAK, retransmit.
// [RULE_15] bad CRC: command dropped silently, ack treated as NAK.
// [RULE_16] command during outstanding data: answer command, then resend.
// [RULE_17] host resends command or NAKs on bad sequence digit.
// [RULE_18] host resends command or NAKs on bad CRC.
// [RULE_19] host resends unanswered command with same sequence digit.
// [RULE_20] host ignores async message while sending a command.
// [RULE_21] host enables parity and keeps timing tight.
// [RULE_22] device async messages use even digits, advance only on ack.
// [RULE_23] host uses odd digits; device echoes command digit.
// [RULE_24] at-sign means ACK, question mark means NAK.
// [RULE_25] timeouts count a millisecond tick, reloaded on each start.
module ecl_link_engine
  import ecl_pkg::*;
#(
  parameter int MS_CYCLES = `ECL_MS_CYCLES
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // receive character stream, one char per pulse
  input  wire ecl_char_type  rx_char,
  // crc verdict of the frame being closed, valid with its end char
  input  wire logic          rx_crc_ok,
  // configuration
  input  wire logic [15:0]   rx_idle_ms,
  input  wire logic [7:0]    rx_max_len,
  input  wire logic [7:0]    errchk_ms,
  input  wire logic [15:0]   new_baud,
  input  wire logic          new_baud_req,
  input  wire logic          cmd_mode,
  // async data message request from the queue
  input  wire logic          data_pending,
  // decoded command from the frame body
  output ecl_frame_type      cmd_frame,
  output logic               cmd_is_rf,
  output logic               cmd_error,
  output logic [11:0]        rf_channel,
  // transmit requests to the framer
  output logic               tx_data_go,
  output logic               tx_resp_go,
  output logic [7:0]         tx_seq,
  input  wire logic          tx_done,
  output logic               data_acked,
  // line and rf state
  output logic [15:0]        baud_rate,
  output logic               rf_enable
);
  initial begin
    if (MS_CYCLES < 2) $error("MS_CYCLES too small");
  end

  // ===================================================================
  // millisecond tick
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic        ms_tick;
  always_comb begin
    ms_tick      = (tick_cnt_ff == 32'(MS_CYCLES - 1));
    nxt_tick_cnt = ms_tick ? 32'h0 : tick_cnt_ff + 32'h1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tick_cnt_ff <= 32'h0;
    else tick_cnt_ff <= nxt_tick_cnt;
  end

  // ===================================================================
  // timeouts derived from baud rate
  logic [15:0] baud_ff, nxt_baud;
  logic [15:0] tchar_ms, rx_to_ms, tx_to_ms;
  always_comb begin
    tchar_ms = 16'((`ECL_MS_PER_S * `ECL_BITS_CHAR + 32'(baud_ff) - 1)
                   / 32'(baud_ff));  // [RULE_05]
    rx_to_ms = 16'(32'(rx_max_len) * (32'(tchar_ms) + 32'(rx_idle_ms)));
    // [RULE_04]
    tx_to_ms = 16'(`ECL_ACK_CHARS * 32'(tchar_ms) + 32'(errchk_ms));
    // [RULE_06]
  end

  // ===================================================================
  // receiver
  logic        in_msg_ff, nxt_in_msg;
  logic [7:0]  pos_ff, nxt_pos;
  logic [15:0] rx_to_ff, nxt_rx_to;
  logic [7:0]  seq_ff, nxt_seq, code_ff, nxt_code;
  logic [11:0] arg_ff, nxt_arg;
  logic        arg_bad_ff, nxt_arg_bad;
  logic [7:0]  cmd_tag_ff [2];
  logic [7:0]  nxt_cmd_tag [2];
  logic        frame_end, is_hex;
  logic [3:0]  hex_val;
  logic [7:0]  c;
  always_comb begin
    c = rx_char.data;
    is_hex = 1'b1;
    hex_val = 4'h0;
    if (c >= 8'h30 && c <= 8'h39) hex_val = 4'(c - 8'h30);
    else if (c >= 8'h41 && c <= 8'h46) hex_val = 4'(c - 8'h37);
    else is_hex = 1'b0;
    nxt_in_msg = in_msg_ff;
    nxt_pos = pos_ff;
    nxt_rx_to = rx_to_ff;
    nxt_seq = seq_ff;
    nxt_code = code_ff;
    nxt_arg = arg_ff;
    nxt_arg_bad = arg_bad_ff;
    nxt_cmd_tag = cmd_tag_ff;
    frame_end = 1'b0;
    if (in_msg_ff && ms_tick) begin
      if (rx_to_ff == 16'h0) nxt_in_msg = 1'b0;  // [RULE_10]
      else nxt_rx_to = rx_to_ff - 16'h1;
    end
    if (rx_char.valid) begin
      if (c == `ECL_CH_SOM) begin
        nxt_in_msg = 1'b1;  // [RULE_11]
        nxt_pos = 8'h0;
        nxt_rx_to = rx_to_ms;  // [RULE_03] [RULE_25]
        nxt_arg = 12'h0;
        nxt_arg_bad = 1'b0;
      end else if (in_msg_ff) begin
        if (c == `ECL_CH_CR) begin
          nxt_in_msg = 1'b0;
          frame_end = 1'b1;
        end else begin
          nxt_pos = pos_ff + 8'h1;
          case (pos_ff)
            8'h0: nxt_seq = c;
            8'h1: nxt_code = c;
            8'h2, 8'h3: nxt_cmd_tag[pos_ff[0]] = c;
            8'h4, 8'h5, 8'h6: begin
              nxt_arg = {arg_ff[7:0], hex_val};
              if (!is_hex) nxt_arg_bad = 1'b1;
            end
            default: nxt_arg_bad = 1'b1;
          endcase
        end
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_msg_ff <= 1'b0;
      pos_ff <= 8'h0;
      rx_to_ff <= 16'h0;
      seq_ff <= 8'h0;
      code_ff <= 8'h0;
      arg_ff <= 12'h0;
      arg_bad_ff <= 1'b0;
      cmd_tag_ff <= '{default: 8'h0};
    end else begin
      in_msg_ff <= nxt_in_msg;
      pos_ff <= nxt_pos;
      rx_to_ff <= nxt_rx_to;
      seq_ff <= nxt_seq;
      code_ff <= nxt_code;
      arg_ff <= nxt_arg;
      arg_bad_ff <= nxt_arg_bad;
      cmd_tag_ff <= nxt_cmd_tag;
    end
  end

  // ===================================================================
  // frame classification
  logic seq_hex, seq_odd, is_ack_fr, rf_cmd, rf_ok;
  always_comb begin
    seq_hex = (seq_ff >= 8'h30 && seq_ff <= 8'h39) ||
              (seq_ff >= 8'h41 && seq_ff <= 8'h46);
    seq_odd = seq_ff[0];
    is_ack_fr = (code_ff == `ECL_CH_ACK || code_ff == `ECL_CH_NAK) &&
                pos_ff == 8'h2;
    rf_cmd = code_ff == 8'h36 && cmd_tag_ff[0] == 8'h34 &&
             cmd_tag_ff[1] == 8'h37;
    rf_ok = pos_ff == 8'h7 && !arg_bad_ff && arg_ff <= `ECL_CHAN_MAX;
    // [RULE_01]
  end

  // ===================================================================
  // transmit / ack state machine
  ecl_tx_state_type st_ff, nxt_st, ret_st_ff, nxt_ret_st;
  logic [15:0] tx_to_ff, nxt_tx_to;
  logic [3:0]  dseq_ff, nxt_dseq;
  logic [7:0]  rseq_ff, nxt_rseq;
  logic        err_ff, nxt_err, isrf_ff, nxt_isrf;
  logic [11:0] chan_ff, nxt_chan;
  logic        baud_req_ff, nxt_baud_req, acked;
  logic [15:0] pend_baud_ff, nxt_pend_baud;
  logic        good_cmd;
  always_comb begin
    nxt_st = st_ff;
    nxt_ret_st = ret_st_ff;
    nxt_tx_to = tx_to_ff;
    nxt_dseq = dseq_ff;
    nxt_rseq = rseq_ff;
    nxt_err = err_ff;
    nxt_isrf = isrf_ff;
    nxt_chan = chan_ff;
    nxt_baud = baud_ff;
    nxt_baud_req = baud_req_ff | new_baud_req;
    nxt_pend_baud = new_baud_req ? new_baud : pend_baud_ff;
    acked = 1'b0;
    good_cmd = frame_end && rx_crc_ok && seq_hex && !is_ack_fr;
    // [RULE_13] [RULE_15]
    case (st_ff)
      ECL_TX_IDLE: if (data_pending) begin
        nxt_st = ECL_TX_WAIT;
        nxt_tx_to = tx_to_ms;  // [RULE_25]
      end
      ECL_TX_WAIT: begin
        if (ms_tick) begin
          if (tx_to_ff == 16'h0) nxt_tx_to = tx_to_ms;  // [RULE_09]
          else nxt_tx_to = tx_to_ff - 16'h1;
        end
        if (frame_end && is_ack_fr) begin
          if (rx_crc_ok && seq_hex && code_ff == `ECL_CH_ACK &&
              hex_of(seq_ff) == dseq_ff) begin  // [RULE_14] [RULE_24]
            acked = 1'b1;
            nxt_dseq = dseq_ff + 4'h2;  // [RULE_22]
            nxt_st = ECL_TX_IDLE;
          end else begin
            nxt_tx_to = tx_to_ms;  // [RULE_13] [RULE_14] [RULE_15]
          end
        end
      end
      ECL_TX_CMD: if (tx_done) nxt_st = ECL_TX_RESP;
      ECL_TX_RESP: begin
        nxt_st = ret_st_ff;
        nxt_tx_to = tx_to_ms;  // [RULE_16]
        if (baud_req_ff) begin
          nxt_baud = pend_baud_ff;  // [RULE_07]
          nxt_baud_req = 1'b0;
        end
      end
      default: nxt_st = ECL_TX_IDLE;
    endcase
    if (good_cmd && st_ff != ECL_TX_CMD && st_ff != ECL_TX_RESP) begin
      nxt_ret_st = (st_ff == ECL_TX_WAIT) ? ECL_TX_WAIT : ECL_TX_IDLE;
      nxt_st = ECL_TX_CMD;
      nxt_rseq = seq_ff;  // [RULE_23]
      nxt_isrf = rf_cmd;
      nxt_err = rf_cmd && !rf_ok;  // [RULE_02]
      if (rf_cmd && rf_ok) nxt_chan = arg_ff;
    end
  end
  function automatic logic [3:0] hex_of(input logic [7:0] ch);
    hex_of = (ch <= 8'h39) ? 4'(ch - 8'h30) : 4'(ch - 8'h37);
  endfunction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ECL_TX_IDLE;
      ret_st_ff <= ECL_TX_IDLE;
      tx_to_ff <= 16'h0;
      dseq_ff <= 4'h0;
      rseq_ff <= 8'h0;
      err_ff <= 1'b0;
      isrf_ff <= 1'b0;
      chan_ff <= 12'h0;
      baud_ff <= 16'(`ECL_BAUD_RST);
      baud_req_ff <= 1'b0;
      pend_baud_ff <= 16'(`ECL_BAUD_RST);
    end else begin
      st_ff <= nxt_st;
      ret_st_ff <= nxt_ret_st;
      tx_to_ff <= nxt_tx_to;
      dseq_ff <= nxt_dseq;
      rseq_ff <= nxt_rseq;
      err_ff <= nxt_err;
      isrf_ff <= nxt_isrf;
      chan_ff <= nxt_chan;
      baud_ff <= nxt_baud;
      baud_req_ff <= nxt_baud_req;
      pend_baud_ff <= nxt_pend_baud;
    end
  end

  // ===================================================================
  // outputs
  logic resend;
  always_comb begin
    resend = st_ff == ECL_TX_WAIT && ((ms_tick && tx_to_ff == 16'h0) ||
             (frame_end && is_ack_fr && !acked));
    tx_data_go = (st_ff == ECL_TX_IDLE && data_pending && !good_cmd) ||
                 (resend && !good_cmd);  // [RULE_09] [RULE_16]
    tx_resp_go = st_ff == ECL_TX_CMD;
    tx_seq = (st_ff == ECL_TX_CMD) ? rseq_ff :
             ((dseq_ff <= 4'h9) ? 8'h30 + 8'(dseq_ff)
                                : 8'h37 + 8'(dseq_ff));
    data_acked = acked;
    cmd_frame = '{valid: st_ff == ECL_TX_CMD, is_ack: 1'b0,
                  crc_ok: 1'b1, seq: rseq_ff, code: code_ff};
    cmd_is_rf = isrf_ff;
    cmd_error = err_ff;
    rf_channel = chan_ff;
    baud_rate = baud_ff;
    rf_enable = !cmd_mode;  // [RULE_12]
  end

  // ===================================================================
  // checks
  property p_rf_off;  // [RULE_12]
    @(posedge clk) disable iff (!reset_n) cmd_mode |-> !rf_enable;
  endproperty
  a_rf_off: assert property (p_rf_off) else $error("rf on in cmd mode");
  property p_even_seq;  // [RULE_22]
    @(posedge clk) disable iff (!reset_n) dseq_ff[0] == 1'b0;
  endproperty
  a_even_seq: assert property (p_even_seq) else $error("odd data seq");
  property p_ack_adv;  // [RULE_22]
    @(posedge clk) disable iff (!reset_n)
      data_acked |=> dseq_ff == $past(dseq_ff) + 4'h2;
  endproperty
  a_ack_adv: assert property (p_ack_adv) else $error("seq not advanced");
  property p_no_adv;  // [RULE_14]
    @(posedge clk) disable iff (!reset_n)
      !data_acked |=> $stable(dseq_ff);
  endproperty
  a_no_adv: assert property (p_no_adv) else $error("seq moved w/o ack");
  property p_bad_drop;  // [RULE_15]
    @(posedge clk) disable iff (!reset_n)
      (st_ff == ECL_TX_IDLE && frame_end && !rx_crc_ok) |=> !tx_resp_go;
  endproperty
  a_bad_drop: assert property (p_bad_drop) else $error("reply to bad crc");
  property p_echo;  // [RULE_23]
    @(posedge clk) disable iff (!reset_n) tx_resp_go |-> tx_seq == rseq_ff;
  endproperty
  a_echo: assert property (p_echo) else $error("seq not echoed");
  property p_rf_range;  // [RULE_01]
    @(posedge clk) disable iff (!reset_n) rf_channel <= `ECL_CHAN_MAX;
  endproperty
  a_rf_range: assert property (p_rf_range) else $error("channel range");
  property p_baud_after;  // [RULE_07]
    @(posedge clk) disable iff (!reset_n)
      st_ff != ECL_TX_RESP |=> $stable(baud_rate);
  endproperty
  a_baud_after: assert property (p_baud_after) else $error("early baud");
endmodule

// >>> bench/ecl_host_model.sv
`timescale 1ns/100ps
// =========================================
// host side of the link, character level
module ecl_host_model
  import ecl_pkg::*;
(
  // clock and reset
  input  wire logic    clk,
  input  wire logic    reset_n,
  // characters toward the engine
  output ecl_char_type rx_char,
  output logic         rx_crc_ok,
  // response handshake
  input  wire logic    tx_resp_go,
  output logic         tx_done
);
  int cnt_ff;

  initial begin
    rx_char   = '0;
    rx_crc_ok = 1'b0;
    tx_done   = 1'b0;
  end

  // one char a cycle; released line shows inverse of last char
  task automatic send_frame(input string s, input bit crc, input bit eom);
    logic [7:0] ch;
    for (int i = 0; i < s.len() + eom; i++) begin
      ch = (i < s.len()) ? s[i] : 8'h0D;
      rx_char   <= '{valid: 1'b1, data: ch};
      rx_crc_ok <= crc;
      @(posedge clk);
    end
    rx_char   <= '{valid: 1'b0, data: ~ch};
    rx_crc_ok <= ~crc;
  endtask

  // answers a response request a few cycles late
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff  <= 0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      cnt_ff  <= 0;
      if (tx_resp_go && !tx_done) begin
        cnt_ff  <= cnt_ff + 1;
        tx_done <= (cnt_ff == 3);
      end
    end
  end
endmodule

// >>> bench/tb.sv
`timescale 1ns/100ps
module tb
  import ecl_pkg::*;
;
  logic          clk, reset_n, rx_crc_ok, new_baud_req, cmd_mode;
  ecl_char_type  rx_char;
  logic [15:0]   rx_idle_ms, new_baud, baud_rate;
  logic [7:0]    rx_max_len, errchk_ms, tx_seq, go_seq;
  logic          data_pending, cmd_is_rf, cmd_error, rf_enable;
  ecl_frame_type cmd_frame;
  logic [11:0]   rf_channel;
  logic          tx_data_go, tx_resp_go, tx_done, data_acked;
  int            n_errors, checks_done, n_go, n_acked;

  ecl_link_engine #(.MS_CYCLES(4)) u_dut (
    .clk(clk), .reset_n(reset_n), .rx_char(rx_char),
    .rx_crc_ok(rx_crc_ok), .rx_idle_ms(rx_idle_ms),
    .rx_max_len(rx_max_len), .errchk_ms(errchk_ms), .new_baud(new_baud),
    .new_baud_req(new_baud_req), .cmd_mode(cmd_mode),
    .data_pending(data_pending), .cmd_frame(cmd_frame),
    .cmd_is_rf(cmd_is_rf), .cmd_error(cmd_error), .rf_channel(rf_channel),
    .tx_data_go(tx_data_go), .tx_resp_go(tx_resp_go), .tx_seq(tx_seq),
    .tx_done(tx_done), .data_acked(data_acked), .baud_rate(baud_rate),
    .rf_enable(rf_enable));

  ecl_host_model u_host (
    .clk(clk), .reset_n(reset_n), .rx_char(rx_char),
    .rx_crc_ok(rx_crc_ok), .tx_resp_go(tx_resp_go), .tx_done(tx_done));

  always #12.5 clk = ~clk;

  // =========================================
  // pulse counters, sampled mid-cycle
  always @(negedge clk) begin
    if (tx_data_go === 1'b1) begin
      n_go   = n_go + 1;
      go_seq = tx_seq;
    end
    if (data_acked === 1'b1)
      n_acked = n_acked + 1;
  end

  // =========================================
  // helpers
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_go(input int c0, input int max, input bit must);
    for (int i = 0; i < max && n_go == c0; i++) @(negedge clk);
    chk((n_go != c0) == must, "data message request");
    if (must && n_go == c0) give_verdict();
  endtask

  task automatic cmd(input string s, input bit legal, input logic [11:0] ch);
    u_host.send_frame(s, 1'b1, 1'b1);
    @(negedge clk);
    chk(tx_resp_go === 1'b1 && cmd_frame.valid === 1'b1, "no reply");
    chk(tx_seq === s[1], "seq echo");
    chk(cmd_frame.seq === s[1] && cmd_frame.code === s[2], "frame");
    chk(cmd_is_rf === 1'b1 && cmd_error === !legal, "decode");
    if (legal) chk(rf_channel === ch, "channel");
    for (int i = 0; i < 20 && tx_resp_go !== 1'b0; i++) @(negedge clk);
    chk(tx_resp_go === 1'b0, "reply stuck");
    if (tx_resp_go !== 1'b0) give_verdict();
    @(posedge clk);
  endtask

  task automatic no_resp(input string s, input bit crc);
    bit seen;
    seen = 1'b0;
    u_host.send_frame(s, crc, 1'b1);
    repeat (30) begin
      @(negedge clk);
      if (tx_resp_go !== 1'b0) seen = 1'b1;
    end
    chk(!seen, "unexpected reply");
    @(posedge clk);
  endtask

  task automatic ack(input string s, input bit crc, input bit good);
    int c0, a0;
    c0 = n_go;
    a0 = n_acked;
    u_host.send_frame(s, crc, 1'b1);
    wait_go(c0, good ? 80 : 3, !good || data_pending === 1'b1);
    chk((n_acked != a0) == good, "ack accept");
    @(posedge clk);
  endtask

  // =========================================
  // scenarios
  task automatic t_reset();
    @(negedge clk);
    chk(tx_seq === 8'h30 && baud_rate === 16'h2580, "reset state");
    chk(tx_resp_go === 1'b0 && tx_data_go === 1'b0, "reset requests");
    @(posedge clk);
    cmd_mode <= 1'b1;
    @(negedge clk);
    chk(rf_enable === 1'b0, "rf on in command mode");
    @(posedge clk);
    cmd_mode <= 1'b0;
    @(negedge clk);
    chk(rf_enable === 1'b1, "rf off in data mode");
    @(posedge clk);
  endtask

  task automatic t_cmds();
    cmd("#7647010", 1'b1, 12'h010);
    cmd("#9647118", 1'b1, 12'h118);
    cmd("#B647119", 1'b0, 12'h000);
    cmd("#D6471G0", 1'b0, 12'h000);
  endtask

  task automatic t_drop();
    no_resp("#7647010", 1'b0);
    no_resp("#G647010", 1'b1);
    cmd("#7647010", 1'b1, 12'h010);
    u_host.send_frame("#7647", 1'b1, 1'b0);
    repeat (600) @(posedge clk);
    no_resp("010", 1'b1);
    u_host.send_frame("#76", 1'b1, 1'b0);
    @(posedge clk);
    cmd("#7647005", 1'b1, 12'h005);
  endtask

  task automatic t_data();
    data_pending <= 1'b1;
    wait_go(n_go, 50, 1'b1);
    chk(go_seq === 8'h30, "first data seq");
    @(posedge clk);
    ack("#2@", 1'b1, 1'b0);
    ack("#0?", 1'b1, 1'b0);
    ack("#0@", 1'b0, 1'b0);
    ack("#G@", 1'b1, 1'b0);
    wait_go(n_go, 300, 1'b1);
    @(posedge clk);
    ack("#0@", 1'b1, 1'b1);
    chk(go_seq === 8'h32, "seq advance");
    data_pending <= 1'b0;
    ack("#2@", 1'b1, 1'b1);
  endtask

  task automatic t_collide();
    int c0;
    data_pending <= 1'b1;
    wait_go(n_go, 50, 1'b1);
    @(posedge clk);
    c0 = n_go;
    cmd("#9647001", 1'b1, 12'h001);
    chk(n_go == c0, "data before reply");
    wait_go(c0, 300, 1'b1);
    @(posedge clk);
    data_pending <= 1'b0;
    ack($sformatf("#%c@", go_seq), 1'b1, 1'b1);
  endtask

  task automatic t_baud();
    new_baud     <= 16'h4B00;
    new_baud_req <= 1'b1;
    @(posedge clk);
    new_baud_req <= 1'b0;
    u_host.send_frame("#B647002", 1'b1, 1'b1);
    for (int i = 0; i < 20 && tx_done !== 1'b1; i++) @(negedge clk);
    chk(tx_done === 1'b1 && baud_rate === 16'h2580, "baud early");
    @(negedge clk);
    chk(baud_rate === 16'h2580, "baud before reply end");
    @(negedge clk);
    chk(baud_rate === 16'h4B00, "baud not applied");
    @(posedge clk);
  endtask

  initial begin
    clk          = 1'b0;
    reset_n      = 1'b0;
    rx_idle_ms   = 16'h0001;
    rx_max_len   = 8'h10;
    errchk_ms    = 8'h02;
    new_baud     = 16'h2580;
    new_baud_req = 1'b0;
    cmd_mode     = 1'b0;
    data_pending = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_cmds();
    t_drop();
    t_data();
    t_collide();
    t_baud();
    give_verdict();
  end
endmodule
